// ### core/alsr_top.sv
// Contract
// - Registers are 16-bit words chosen by an 8-bit command code from zero.
// - Configuration word resets to one, so the sensor starts shut down.
// - Config bit 0 low powers measurement on; high shuts it down.
// - Configuration word is read/write with gain, period, interrupt, shutdown fields.
// - High threshold word at code one is read/write, high byte in 15:8.
// - Low threshold word at code two is read/write, high byte in 15:8.
// - Ambient result is read-only at code four, high byte in 15:8.
// - Broadband result is read-only at code five, high byte in 15:8.
// - Gain field 12:11 selects x1, x2, x1/8, x1/4.
// - Period field 9:6 selects 25 to 800 ms.
// - Shutdown keeps the last ambient result readable until fresh data after wake.
`timescale 1ns/1ps
module alsr_top
	import alsr_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR    = 7'h2a,
	parameter logic [15:0] DEVICE_ID   = 16'h5a3c, // Arbitrary identity value
	parameter int unsigned WAKE_CYC    = WAKE_CYCLES,
	parameter int unsigned IT_BASE_CYC = IT_BASE_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic [15:0] fe_ambient_count,
	input  wire logic [15:0] fe_broadband_count,
	output logic             fe_power_on,
	output logic [4:0]       fe_gain_eighths,
	output logic [3:0]       fe_period_select,
	output logic             fe_capture
);
	logic [1:0]    rst_pipe;
	logic          rst_sync_n;
	alsr_i2c_evt_t evt;
	logic [7:0]    tx_byte_reg;
	logic [7:0]    cmd_reg;
	logic [7:0]    wr_low_reg;
	logic          byte_hi_reg;
	logic [15:0]   shadow_reg;
	logic [15:0]   light_config_reg;
	logic [15:0]   high_threshold_reg;
	logic [15:0]   low_threshold_reg;
	logic [15:0]   power_saving_setting_reg;
	logic [15:0]   ambient_result_reg;
	logic [15:0]   broadband_result_reg;
	logic [15:0]   threshold_event_flags_reg;
	logic [15:0]   event_set;
	logic [15:0]   event_clr;
	logic [15:0]   read_word;
	logic [15:0]   wr_word;
	logic          wr_stb;
	logic          rd_first;
	logic          period_done;
	logic          shutdown_bit;
	logic          int_enable;

	// Reset released through two flops, frozen with the clock enable
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe <= 2'b00;
		end else if (ce) begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe[1];

	alsr_i2c_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_serial (
		.clk_sys (clk_sys),
		.rst_n   (rst_sync_n),
		.ce      (ce),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.sda_out (sda_out),
		.sda_oe  (sda_oe),
		.tx_byte (tx_byte_reg),
		.evt     (evt)
	);

	assign shutdown_bit = light_config_reg[SD_BIT];
	assign int_enable   = light_config_reg[INT_EN_BIT];

	alsr_meas #(
		.WAKE_CYC    (WAKE_CYC),
		.IT_BASE_CYC (IT_BASE_CYC)
	) u_meas (
		.clk_sys     (clk_sys),
		.rst_n       (rst_sync_n),
		.ce          (ce),
		.enable      (~shutdown_bit),
		.it_sel      (light_config_reg[IT_LSB +: 4]),
		.period_done (period_done),
		.integrating ()
	);

	// A word write lands only when its high byte arrives; a lone low byte is dropped
	assign wr_stb   = evt.rx_valid & ~evt.rx_first & byte_hi_reg;
	assign wr_word  = {evt.rx_data, wr_low_reg};
	assign rd_first = evt.tx_req & evt.tx_first;

	// Command pointer and byte pairing, low byte first on the wire
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_reg     <= 8'h00;
			wr_low_reg  <= 8'h00;
			byte_hi_reg <= 1'b0;
		end else if (ce) begin
			if (!rst_sync_n || evt.stop) begin
				byte_hi_reg <= 1'b0;
			end else if (evt.rx_valid && evt.rx_first) begin
				cmd_reg     <= evt.rx_data;
				byte_hi_reg <= 1'b0;
			end else if (evt.rx_valid) begin
				wr_low_reg  <= evt.rx_data;
				byte_hi_reg <= ~byte_hi_reg;
			end else if (evt.tx_req) begin
				byte_hi_reg <= rd_first ? 1'b1 : ~byte_hi_reg;
			end
		end
	end

	// Read decode; unmapped codes read as zero
	always_comb begin
		if (cmd_reg == CODE_CONFIG) begin
			read_word = light_config_reg;
		end else if (cmd_reg == CODE_HIGH_TH) begin
			read_word = high_threshold_reg;
		end else if (cmd_reg == CODE_LOW_TH) begin
			read_word = low_threshold_reg;
		end else if (cmd_reg == CODE_PSAVE) begin
			read_word = power_saving_setting_reg;
		end else if (cmd_reg == CODE_AMBIENT) begin
			read_word = ambient_result_reg;
		end else if (cmd_reg == CODE_BROADBAND) begin
			read_word = broadband_result_reg;
		end else if (cmd_reg == CODE_EVENTS) begin
			read_word = threshold_event_flags_reg;
		end else if (cmd_reg == CODE_IDENT) begin
			read_word = DEVICE_ID;
		end else begin
			read_word = WORD_RESET;
		end
	end

	// Whole word snapshot at read start so both bytes come from one period
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shadow_reg  <= 16'h0000;
			tx_byte_reg <= 8'h00;
		end else if (ce) begin
			if (rd_first) begin
				shadow_reg  <= read_word;
				tx_byte_reg <= read_word[7:0];
			end else if (evt.tx_req) begin
				tx_byte_reg <= byte_hi_reg ? shadow_reg[15:8] : shadow_reg[7:0];
			end
		end
	end

	// Writable registers; writes to read-only codes are ignored
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			light_config_reg         <= CONFIG_RESET;
			high_threshold_reg       <= WORD_RESET;
			low_threshold_reg        <= WORD_RESET;
			power_saving_setting_reg <= WORD_RESET;
		end else if (ce) begin
			if (!rst_sync_n) begin
				light_config_reg <= CONFIG_RESET;
			end else if (wr_stb && cmd_reg == CODE_CONFIG) begin
				light_config_reg <= wr_word;
			end else if (wr_stb && cmd_reg == CODE_HIGH_TH) begin
				high_threshold_reg <= wr_word;
			end else if (wr_stb && cmd_reg == CODE_LOW_TH) begin
				low_threshold_reg <= wr_word;
			end else if (wr_stb && cmd_reg == CODE_PSAVE) begin
				// Stored as written; upper bits are the host's to keep clear
				power_saving_setting_reg <= wr_word;
			end
		end
	end

	// Results replaced together at period end only; shutdown leaves them standing
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ambient_result_reg   <= WORD_RESET;
			broadband_result_reg <= WORD_RESET;
		end else if (ce && period_done) begin
			ambient_result_reg   <= fe_ambient_count;
			broadband_result_reg <= fe_broadband_count;
		end
	end

	// Window events: set wins over the clear-on-read in the same cycle
	always_comb begin
		event_set = 16'h0000;
		event_clr = 16'h0000;
		if (period_done && int_enable) begin
			event_set[EVT_HIGH_BIT] = fe_ambient_count > high_threshold_reg;
			event_set[EVT_LOW_BIT]  = fe_ambient_count < low_threshold_reg;
		end
		if (rd_first && cmd_reg == CODE_EVENTS) begin
			event_clr = 16'hffff;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			threshold_event_flags_reg <= WORD_RESET;
		end else if (ce) begin
			threshold_event_flags_reg <= (threshold_event_flags_reg & ~event_clr) | event_set;
		end
	end

	// Front-end controls from flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fe_power_on      <= 1'b0;
			fe_gain_eighths  <= 5'h08;
			fe_period_select <= IT_100;
			fe_capture       <= 1'b0;
		end else if (ce) begin
			fe_power_on      <= ~shutdown_bit;
			fe_gain_eighths  <= gain_eighths(light_config_reg[GAIN_LSB +: 2]);
			fe_period_select <= light_config_reg[IT_LSB +: 4];
			fe_capture       <= period_done;
		end
	end

	AST_CONFIG_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!rst_sync_n ##1 rst_sync_n |-> light_config_reg == CONFIG_RESET)
		else $error("configuration word not one after reset");
	AST_CONFIG_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && wr_stb && cmd_reg == CODE_CONFIG |=> light_config_reg == $past(wr_word))
		else $error("configuration write not stored");
	AST_HIGH_TH_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && wr_stb && cmd_reg == CODE_HIGH_TH
		|=> high_threshold_reg[15:8] == $past(evt.rx_data)
		&& high_threshold_reg[7:0] == $past(wr_low_reg))
		else $error("high threshold bytes misplaced");
	AST_LOW_TH_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && wr_stb && cmd_reg == CODE_LOW_TH |=> low_threshold_reg == $past(wr_word))
		else $error("low threshold write not stored");
	AST_SHUTDOWN_STOPS: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && shutdown_bit |=> !period_done && !fe_power_on)
		else $error("measurement continued in shutdown");
	AST_RESULT_RETAIN: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		shutdown_bit && !period_done |=> $stable(ambient_result_reg))
		else $error("ambient result lost in shutdown");
	AST_RESULT_READONLY: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		!period_done |=> $stable(ambient_result_reg) && $stable(broadband_result_reg))
		else $error("result changed outside a period end");
	AST_RESULT_UPDATE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && period_done |=> ambient_result_reg == $past(fe_ambient_count)
		&& broadband_result_reg == $past(fe_broadband_count))
		else $error("results not captured together");
	AST_READ_LOW_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && rd_first |=> tx_byte_reg == $past(read_word[7:0]))
		else $error("first read byte is not the low byte");
	AST_GAIN_DECODE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && light_config_reg[GAIN_LSB +: 2] == GAIN_X1_8 |=> fe_gain_eighths == 5'h01)
		else $error("gain one eighth not decoded");

	// Pointer, snapshot and front-end copies, checked one cycle after the cause
	AST_CMD_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && evt.rx_valid && evt.rx_first |=> cmd_reg == $past(evt.rx_data))
		else $error("command code not captured");
	AST_SNAPSHOT: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && rd_first |=> shadow_reg == $past(read_word))
		else $error("read snapshot not taken");
	AST_READ_HIGH_SECOND: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && evt.tx_req && !evt.tx_first && byte_hi_reg
		|=> tx_byte_reg == $past(shadow_reg[15:8]))
		else $error("second read byte is not the high byte");
	AST_POWER_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && !shutdown_bit |=> fe_power_on)
		else $error("front end not powered with shutdown clear");
	AST_PERIOD_SELECT: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce |=> fe_period_select == $past(light_config_reg[IT_LSB +: 4]))
		else $error("period select not copied from configuration");

	// Window events must survive a clear-on-read in the same cycle
	AST_HIGH_EVENT: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && period_done && int_enable && fe_ambient_count > high_threshold_reg
		|=> threshold_event_flags_reg[EVT_HIGH_BIT])
		else $error("high window event not flagged");
	AST_LOW_EVENT: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && period_done && int_enable && fe_ambient_count < low_threshold_reg
		|=> threshold_event_flags_reg[EVT_LOW_BIT])
		else $error("low window event not flagged");
	AST_EVENT_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ce && rd_first && cmd_reg == CODE_EVENTS && !period_done
		|=> threshold_event_flags_reg == WORD_RESET)
		else $error("event word not cleared by its read");

	if (IT_BASE_CYC < 1 || WAKE_CYC < 1) begin : g_chk
		$error("alsr_top: timing counts must be at least one");
	end
endmodule

// ### core/alsr_pkg.sv
package alsr_pkg;
	// Command codes of the 16-bit word registers
	localparam logic [7:0] CODE_CONFIG    = 8'h00;
	localparam logic [7:0] CODE_HIGH_TH   = 8'h01;
	localparam logic [7:0] CODE_LOW_TH    = 8'h02;
	localparam logic [7:0] CODE_PSAVE     = 8'h03;
	localparam logic [7:0] CODE_AMBIENT   = 8'h04;
	localparam logic [7:0] CODE_BROADBAND = 8'h05;
	localparam logic [7:0] CODE_EVENTS    = 8'h06;
	localparam logic [7:0] CODE_IDENT     = 8'h07;

	// Reset values and field positions
	localparam logic [15:0] CONFIG_RESET = 16'h0001;
	localparam logic [15:0] WORD_RESET   = 16'h0000;
	localparam int          SD_BIT       = 0;
	localparam int          INT_EN_BIT   = 1;
	localparam int          IT_LSB       = 6;
	localparam int          GAIN_LSB     = 11;
	localparam int          EVT_HIGH_BIT = 15;
	localparam int          EVT_LOW_BIT  = 14;

	// Integration period codes and gain codes
	localparam logic [3:0] IT_25  = 4'hc;
	localparam logic [3:0] IT_50  = 4'h8;
	localparam logic [3:0] IT_100 = 4'h0;
	localparam logic [3:0] IT_200 = 4'h1;
	localparam logic [3:0] IT_400 = 4'h2;
	localparam logic [3:0] IT_800 = 4'h3;
	localparam logic [1:0] GAIN_X1   = 2'h0;
	localparam logic [1:0] GAIN_X2   = 2'h1;
	localparam logic [1:0] GAIN_X1_8 = 2'h2;
	localparam logic [1:0] GAIN_X1_4 = 2'h3;

	// Timing, clock at 40 MHz
	localparam int CLK_PERIOD_NS  = 25;
	localparam int WAKE_TIME_NS   = 2500000;
	localparam int WAKE_CYCLES    = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IT_BASE_NS     = 25000000;
	localparam int IT_BASE_CYCLES = IT_BASE_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {MEAS_OFF, MEAS_WAKE, MEAS_INTEG} alsr_meas_state_t;
	typedef enum logic [2:0] {
		I2C_IDLE, I2C_RX, I2C_ACK_WAIT, I2C_ACK_DRIVE, I2C_TX, I2C_HACK, I2C_HACK_END
	} alsr_i2c_state_t;

	// Byte events from the serial engine to the register file
	typedef struct packed {
		logic       rx_valid;
		logic       rx_first;
		logic [7:0] rx_data;
		logic       tx_req;
		logic       tx_first;
		logic       stop;
	} alsr_i2c_evt_t;

	// Period length in units of 25 ms; unknown codes run as 100 ms
	function automatic logic [5:0] it_multiplier(input logic [3:0] code);
		case (code)
			IT_25:   it_multiplier = 6'h01;
			IT_50:   it_multiplier = 6'h02;
			IT_200:  it_multiplier = 6'h08;
			IT_400:  it_multiplier = 6'h10;
			IT_800:  it_multiplier = 6'h20;
			default: it_multiplier = 6'h04;
		endcase
	endfunction

	// Front-end gain expressed in eighths
	function automatic logic [4:0] gain_eighths(input logic [1:0] code);
		case (code)
			GAIN_X2:   gain_eighths = 5'h10;
			GAIN_X1_8: gain_eighths = 5'h01;
			GAIN_X1_4: gain_eighths = 5'h02;
			default:   gain_eighths = 5'h08;
		endcase
	endfunction
endpackage

// ### core/alsr_i2c_slave.sv
`timescale 1ns/1ps
module alsr_i2c_slave
	import alsr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic          ce,
	input  wire logic          scl_in,
	input  wire logic          sda_in,
	output logic               sda_out,
	output logic               sda_oe,
	input  wire logic [7:0]    tx_byte,
	output alsr_i2c_evt_t      evt
);
	logic [2:0]      scl_p;
	logic [2:0]      sda_p;
	logic            scl_rise;
	logic            scl_fall;
	logic            start_c;
	logic            stop_c;
	alsr_i2c_state_t state;
	logic [2:0]      bit_cnt;
	logic [7:0]      shift;
	logic            is_addr;
	logic            rd_mode;
	logic            first;

	// Pins pass three flops; edges read only stages 1 and 2
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_p <= 3'h7;
			sda_p <= 3'h7;
		end else if (ce) begin
			scl_p <= {scl_p[1:0], scl_in};
			sda_p <= {sda_p[1:0], sda_in};
		end
	end

	assign scl_rise = scl_p[1] & ~scl_p[2];
	assign scl_fall = ~scl_p[1] & scl_p[2];
	assign start_c  = scl_p[1] & scl_p[2] & sda_p[2] & ~sda_p[1];
	assign stop_c   = scl_p[1] & scl_p[2] & ~sda_p[2] & sda_p[1];
	// Open drain: only ever pulls low
	assign sda_out  = 1'b0;

	// Byte engine; no clock stretching, so the register file must answer fast
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state   <= I2C_IDLE;
			bit_cnt <= 3'h0;
			shift   <= 8'h00;
			is_addr <= 1'b0;
			rd_mode <= 1'b0;
			first   <= 1'b0;
			sda_oe  <= 1'b0;
			evt     <= '0;
		end else if (ce) begin
			evt <= '0;
			if (start_c) begin
				state   <= I2C_RX;
				bit_cnt <= 3'h0;
				is_addr <= 1'b1;
				sda_oe  <= 1'b0;
			end else if (stop_c) begin
				state    <= I2C_IDLE;
				sda_oe   <= 1'b0;
				evt.stop <= 1'b1;
			end else begin
				case (state)
					I2C_RX: begin
						if (scl_rise) begin
							shift   <= {shift[6:0], sda_p[1]};
							bit_cnt <= bit_cnt + 3'h1;
							if (bit_cnt == 3'h7) begin
								if (!is_addr) begin
									evt.rx_valid <= 1'b1;
									evt.rx_first <= first;
									evt.rx_data  <= {shift[6:0], sda_p[1]};
									first        <= 1'b0;
									state        <= I2C_ACK_WAIT;
								end else if (shift[6:0] == DEV_ADDR) begin
									rd_mode      <= sda_p[1];
									first        <= 1'b1;
									evt.tx_req   <= sda_p[1];
									evt.tx_first <= sda_p[1];
									state        <= I2C_ACK_WAIT;
								end else begin
									state <= I2C_IDLE;
								end
							end
						end
					end
					I2C_ACK_WAIT: begin
						if (scl_fall) begin
							sda_oe <= 1'b1;
							state  <= I2C_ACK_DRIVE;
						end
					end
					I2C_ACK_DRIVE: begin
						if (scl_fall) begin
							bit_cnt <= 3'h0;
							is_addr <= 1'b0;
							if (is_addr && rd_mode) begin
								shift  <= tx_byte;
								sda_oe <= ~tx_byte[7];
								state  <= I2C_TX;
							end else begin
								sda_oe <= 1'b0;
								state  <= I2C_RX;
							end
						end
					end
					I2C_TX: begin
						if (scl_fall) begin
							if (bit_cnt == 3'h7) begin
								sda_oe <= 1'b0;
								state  <= I2C_HACK;
							end else begin
								shift   <= {shift[6:0], 1'b0};
								sda_oe  <= ~shift[6];
								bit_cnt <= bit_cnt + 3'h1;
							end
						end
					end
					I2C_HACK: begin
						// Host acknowledge asks for the next byte; a nack ends the read
						if (scl_rise) begin
							evt.tx_req <= ~sda_p[1];
							state      <= sda_p[1] ? I2C_IDLE : I2C_HACK_END;
						end
					end
					I2C_HACK_END: begin
						if (scl_fall) begin
							shift   <= tx_byte;
							sda_oe  <= ~tx_byte[7];
							bit_cnt <= 3'h0;
							state   <= I2C_TX;
						end
					end
					default: state <= I2C_IDLE;
				endcase
			end
		end
	end
endmodule

// ### core/alsr_meas.sv
`timescale 1ns/1ps
module alsr_meas
	import alsr_pkg::*;
#(
	parameter int unsigned WAKE_CYC    = WAKE_CYCLES,
	parameter int unsigned IT_BASE_CYC = IT_BASE_CYCLES
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       enable,
	input  wire logic [3:0] it_sel,
	output logic            period_done,
	output logic            integrating
);
	alsr_meas_state_t state;
	logic [31:0]      cnt;
	logic [31:0]      period;
	logic [31:0]      on_cnt;
	logic [31:0]      gap;
	logic             it_moved;

	assign period      = IT_BASE_CYC * {26'h0, it_multiplier(it_sel)};
	assign integrating = (state == MEAS_INTEG);

	// Wake-up then back-to-back periods; leaving power-on drops a partial period
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state       <= MEAS_OFF;
			cnt         <= 32'h0;
			period_done <= 1'b0;
		end else if (ce) begin
			period_done <= 1'b0;
			if (!enable) begin
				state <= MEAS_OFF;
				cnt   <= 32'h0;
			end else begin
				case (state)
					MEAS_OFF: begin
						state <= MEAS_WAKE;
						cnt   <= 32'h0;
					end
					MEAS_WAKE: begin
						if (cnt >= WAKE_CYC - 1) begin
							state <= MEAS_INTEG;
							cnt   <= 32'h0;
						end else begin
							cnt <= cnt + 32'h1;
						end
					end
					default: begin
						// Compare with >= so a shortened period mid-count still ends
						if (cnt >= period - 32'h1) begin
							period_done <= 1'b1;
							cnt         <= 32'h0;
						end else begin
							cnt <= cnt + 32'h1;
						end
					end
				endcase
			end
		end
	end

	// Checking aids: time since power-on, time since last period end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			on_cnt   <= 32'h0;
			gap      <= 32'h0;
			it_moved <= 1'b0;
		end else if (ce) begin
			on_cnt   <= enable ? on_cnt + 32'h1 : 32'h0;
			gap      <= (state != MEAS_INTEG) ? 32'h0 : (period_done ? 32'h1 : gap + 32'h1);
			it_moved <= (state != MEAS_INTEG || period_done) ? 1'b0 : (it_moved | $changed(it_sel));
		end
	end

	AST_WAKE_BEFORE_RESULT: assert property (@(posedge clk_sys) disable iff (!rst_n)
		period_done |-> on_cnt > WAKE_CYC)
		else $error("result produced before wake-up time elapsed");
	AST_PERIOD_LENGTH: assert property (@(posedge clk_sys) disable iff (!rst_n)
		period_done && !it_moved && $stable(it_sel) |-> gap == period)
		else $error("integration period length does not match selection");

	if (WAKE_CYC < 1 || IT_BASE_CYC < 1 || IT_BASE_CYC > 32'h07ffffff) begin : g_chk
		$error("alsr_meas: timing counts out of range");
	end
endmodule

// ### tb/alsr_host_model.sv
`timescale 1ns/1ps
// Bus host: drives SCL, pulls SDA low or lets the pull-up raise it
module alsr_host_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	input  wire logic clk_sys,
	input  wire logic sda_oe,
	input  wire logic sda_out,
	output logic      scl_in,
	output logic      sda_in
);
	logic scl_reg = 1'b1;
	logic sda_reg = 1'b1;
	// Wired-AND: a released line reads high through the pull-up
	assign scl_in = scl_reg;
	assign sda_in = sda_reg & (sda_oe ? sda_out : 1'b1);
	// Bit slot of 16 cycles; data moves 2 cycles after SCL falls, well clear of the edge
	task automatic xfer(input logic b, output logic r);
		repeat (2) @(posedge clk_sys);
		sda_reg <= b;
		repeat (6) @(posedge clk_sys);
		scl_reg <= 1'b1;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys) r = sda_in;
		repeat (4) @(posedge clk_sys);
		scl_reg <= 1'b0;
	endtask
	// Start (s=1, SCL left low) or stop (s=0, bus left idle)
	task automatic cond(input logic s);
		repeat (2) @(posedge clk_sys);
		sda_reg <= s;
		repeat (6) @(posedge clk_sys);
		scl_reg <= 1'b1;
		repeat (8) @(posedge clk_sys);
		sda_reg <= ~s;
		repeat (8) @(posedge clk_sys);
		if (s) scl_reg <= 1'b0;
	endtask
	// Eight bits MSB first, then the acknowledge slot
	task automatic octet(input logic [7:0] d, input logic hk, output logic [7:0] q,
			output logic a);
		for (int i = 7; i >= 0; i--) xfer(d[i], q[i]);
		xfer(hk, a);
		a = ~a;
	endtask
	// Word write: code, low byte, high byte
	task automatic write_word(input logic [7:0] c, input logic [15:0] w, output logic ok);
		logic [7:0] q;
		logic [3:0] a;
		cond(1'b1);
		octet({ADDR, 1'b0}, 1'b1, q, a[0]);
		octet(c, 1'b1, q, a[1]);
		octet(w[7:0], 1'b1, q, a[2]);
		octet(w[15:8], 1'b1, q, a[3]);
		cond(1'b0);
		ok = &a;
	endtask
	// Word read with repeated start; host NACKs the high byte
	task automatic read_word(input logic [7:0] c, output logic [15:0] w, output logic ok);
		logic [7:0] q;
		logic [3:0] a;
		cond(1'b1);
		octet({ADDR, 1'b0}, 1'b1, q, a[0]);
		octet(c, 1'b1, q, a[1]);
		cond(1'b1);
		octet({ADDR, 1'b1}, 1'b1, q, a[2]);
		octet(8'hff, 1'b0, w[7:0], a[3]);
		octet(8'hff, 1'b1, w[15:8], a[3]);
		cond(1'b0);
		ok = &a[2:0];
	endtask
endmodule

// ### tb/alsr_top_tb.sv
`timescale 1ns/1ps
// Host model on the bus, front-end counts driven by the bench
module alsr_top_tb
	import alsr_pkg::*;
();
	localparam int          WK     = 20;
	localparam int          IB     = 50;
	localparam logic [15:0] ID_VAL = 16'h3c96; // Arbitrary identity value
	logic        clk_sys = 1'b0;
	logic        rst_n;
	logic        scl_in, sda_in, sda_oe, sda_out, fe_power_on, fe_capture, ok;
	logic [15:0] amb, bb, rd;
	logic [4:0]  gain8;
	logic [3:0]  psel;
	int          n_errors = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          on_cyc = 0;
	int          cap_at = 0;
	int          since = 0;
	int          gap = 0;

	always #12.5 clk_sys = ~clk_sys;

	alsr_top #(.DEVICE_ID(ID_VAL), .WAKE_CYC(WK), .IT_BASE_CYC(IB)) u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .scl_in(scl_in), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .fe_ambient_count(amb), .fe_broadband_count(bb),
		.fe_power_on(fe_power_on), .fe_gain_eighths(gain8), .fe_period_select(psel),
		.fe_capture(fe_capture));
	alsr_host_model u_host (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl_in(scl_in),
		.sda_out(sda_out), .sda_in(sda_in));

	// Power-on to first capture, and spacing of captures
	always @(posedge clk_sys) begin
		on_cyc <= (fe_power_on === 1'b1) ? on_cyc + 1 : 0;
		if (fe_power_on !== 1'b1) cap_at <= 0;
		else if (fe_capture === 1'b1 && cap_at == 0) cap_at <= on_cyc;
		since <= (fe_capture === 1'b1) ? 1 : since + 1;
		if (fe_capture === 1'b1) gap <= since;
	end
	// Hang guard, about two and a half times the expected run
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			final_report();
		end
	end

	task automatic final_report();
		if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] w);
		u_host.write_word(c, w, ok);
		chk("write ack", 16'h1, {15'h0, ok});
	endtask
	task automatic rdw(input logic [7:0] c, output logic [15:0] w);
		u_host.read_word(c, w, ok);
		chk("read ack", 16'h1, {15'h0, ok});
	endtask
	// Bounded wait for one capture pulse, then step past it
	task automatic wait_cap();
		int n = 0;
		@(posedge clk_sys);
		while (fe_capture !== 1'b1 && n < 3000) begin
			@(posedge clk_sys);
			n++;
		end
		chk("capture seen", 16'h1, {15'h0, fe_capture});
		@(posedge clk_sys);
	endtask

	task automatic t_reset();
		chk("power", 16'h0, {15'h0, fe_power_on});
		rdw(CODE_CONFIG, rd);
		chk("config", 16'h0001, rd);
		rdw(CODE_IDENT, rd);
		chk("ident", ID_VAL, rd);
	endtask
	// Power-saving value keeps 15:3 clear
	task automatic t_rw();
		logic [15:0] v[3] = '{16'ha55a, 16'h1e87, 16'h0005};
		for (int i = 0; i < 3; i++) begin
			wr(8'(i + 1), v[i]);
			rdw(8'(i + 1), rd);
			chk("rw word", v[i], rd);
		end
		for (int c = 4; c < 6; c++) begin
			wr(8'(c), 16'hffff);
			rdw(8'(c), rd);
			chk("read-only", 16'h0000, rd);
		end
		rdw(8'h20, rd);
		chk("unmapped", 16'h0000, rd);
	endtask
	// Every period code and gain code, sensor kept shut down
	task automatic t_fields();
		logic [3:0]  it[6] = '{4'hc, 4'h8, 4'h0, 4'h1, 4'h2, 4'h3};
		logic [4:0]  ge[4] = '{5'h08, 5'h10, 5'h01, 5'h02};
		logic [15:0] w;
		for (int i = 0; i < 6; i++) begin
			w = {3'h0, 2'(i % 4), 1'b0, it[i], 6'h01};
			wr(CODE_CONFIG, w);
			repeat (3) @(posedge clk_sys);
			chk("period sel", {12'h0, it[i]}, {12'h0, psel});
			chk("gain", {11'h0, ge[i % 4]}, {11'h0, gain8});
			rdw(CODE_CONFIG, rd);
			chk("config rb", w, rd);
		end
	endtask
	task automatic t_meas();
		amb <= 16'h1234;
		bb <= 16'hbeef;
		wr(CODE_CONFIG, 16'h0300);
		wait_cap();
		chk("wake", 16'h1, 16'(cap_at >= WK + IB - 3 && cap_at <= WK + IB + 3));
		wait_cap();
		chk("period", 16'(IB), gap[15:0]);
		chk("on", 16'h1, {15'h0, fe_power_on});
		rdw(CODE_AMBIENT, rd);
		chk("ambient", 16'h1234, rd);
		rdw(CODE_BROADBAND, rd);
		chk("white", 16'hbeef, rd);
		wr(CODE_CONFIG, 16'h0301);
		amb <= 16'h0f0f;
		repeat (200) @(posedge clk_sys);
		chk("off", 16'h0, {15'h0, fe_power_on});
		rdw(CODE_AMBIENT, rd);
		chk("held", 16'h1234, rd);
		wr(CODE_CONFIG, 16'h0202);
		wait_cap();
		wait_cap();
		chk("period x2", 16'(2 * IB), gap[15:0]);
		rdw(CODE_AMBIENT, rd);
		chk("fresh", 16'h0f0f, rd);
		rdw(CODE_EVENTS, rd);
		chk("events", 16'h4000, rd);
	endtask

	initial begin
		rst_n = 1'b0;
		amb = 16'h0;
		bb = 16'h0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
		t_reset();
		t_rw();
		t_fields();
		t_meas();
		final_report();
	end
endmodule
